// file: hdl/capture_timer.sv
/*
  16-bit up/down timer with prescaler, source select, periodic or
  free-running mode, pending interrupt and event capture register.
  Assumes source ticks and event lines are synchronous to sys_clk.
*/
// The plain strobed port is this design's own decision.
// What this block does
// [R01] 16-bit up/down counter behind selectable prescaler
// [R02] Selected source's rising edge captures the count
// [R03] Count and capture registers read-only, writes ignored
// [R04] Write to clear register drops interrupt unless a timeout comes in the same cycle
// [R05] Reload register supplies the counter's load value
// [R06] Count read returns the present count
// [R07] Control bit 17 gates event capture
// [R08] Control bits 16:12 pick capture source 0-17
// [R09] Control bits 10:9 pick timer clock source
// [R10] Control bit 8 sets direction, down default
// [R11] Control bit 7 runs timer, cleared at reset
// [R12] Control bit 6 picks periodic, free-running default
// [R13] Control bits 3:0 pick prescale divisor
// [R14] Periodic reloads on timeout; free-running wraps; interrupt
// [R15] Interrupt holds until cleared; reserved bits read zero
`timescale 1ns/10ps
`default_nettype none
module capture_timer (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Register port
  input wire capture_timer_pkg::bus_req_s busReq,
  output logic [31:0] rdData,
  // Timer clock source ticks, one sys_clk pulse per source edge
  input wire logic osc32kTick,
  input wire logic coreDivTick,
  input wire logic fastTick,
  // Interrupt sources that may trigger capture
  input wire logic [17:0] eventSources,
  // Pending timer interrupt
  output logic timerIrq
);

  // Software-visible state
  logic [15:0] reload_q; // Load value
  logic [15:0] count_q; // Running count
  logic [31:0] ctrl_q; // Control, reserved bits held zero
  logic [15:0] capt_q; // Captured count
  logic irq_q; // Pending interrupt
  logic [31:0] rdData_q; // Read data, one cycle after strobe
  logic [14:0] preCnt_q; // Prescale divider
  logic evtPrev_q; // Last level of the selected source

  // Decoded control fields
  logic capGate;
  logic [4:0] capSel;
  capture_timer_pkg::clk_src_e clkSel;
  logic countUp;
  logic timerRun;
  logic periodic;
  logic [3:0] scaleSel;

  assign capGate = ctrl_q[capture_timer_pkg::CAP_GATE_BIT]; // [R07]
  assign capSel = ctrl_q[capture_timer_pkg::CAP_SEL_LSB +: 5]; // [R08]
  assign clkSel = capture_timer_pkg::clk_src_e'(
    ctrl_q[capture_timer_pkg::CLK_SEL_LSB +: 2]); // [R09]
  assign countUp = ctrl_q[capture_timer_pkg::DIR_BIT]; // [R10]
  assign timerRun = ctrl_q[capture_timer_pkg::RUN_BIT]; // [R11]
  assign periodic = ctrl_q[capture_timer_pkg::PER_BIT]; // [R12]
  assign scaleSel = ctrl_q[capture_timer_pkg::SCALE_LSB +: 4]; // [R13]

  // Register strobes
  logic wrReload;
  logic wrCtrl;
  logic wrClear;
  logic [15:0] wrData16;
  assign wrReload = busReq.wr &&
    (busReq.addr == capture_timer_pkg::RELOAD_ADDR);
  assign wrCtrl = busReq.wr &&
    (busReq.addr == capture_timer_pkg::CTRL_ADDR);
  assign wrClear = busReq.wr &&
    (busReq.addr == capture_timer_pkg::CLEAR_ADDR);
  assign wrData16 = busReq.wdata[15:0];

  // Source tick select; the reserved code gives no ticks at all
  logic srcTick;
  always_comb begin
    case (clkSel)
      capture_timer_pkg::CLK_OSC32K: srcTick = osc32kTick; // [R09]
      capture_timer_pkg::CLK_CORE_DIV: srcTick = coreDivTick; // [R09]
      capture_timer_pkg::CLK_FAST: srcTick = fastTick; // [R09]
      default: srcTick = 1'b0;
    endcase
  end

  // Prescale terminal count; undefined codes divide by one
  logic [14:0] preTc;
  always_comb begin
    case (scaleSel)
      capture_timer_pkg::SCALE_DIV16:
        preTc = capture_timer_pkg::PRE_TC_16; // [R13]
      capture_timer_pkg::SCALE_DIV256:
        preTc = capture_timer_pkg::PRE_TC_256; // [R13]
      capture_timer_pkg::SCALE_DIV32K:
        preTc = capture_timer_pkg::PRE_TC_32K; // [R13]
      default: preTc = capture_timer_pkg::PRE_TC_1;
    endcase
  end

  // One count step per divided tick while running
  logic preTick;
  logic step;
  assign preTick = srcTick && (preCnt_q >= preTc);
  assign step = timerRun && preTick; // [R11]

  // Prescaler; held clear while stopped so a restart is clean
  always_ff @(posedge sys_clk) begin
    if (!rstn || !timerRun) begin
      preCnt_q <= '0;
    end else if (preTick) begin
      preCnt_q <= '0; // [R13]
    end else if (srcTick) begin
      preCnt_q <= preCnt_q + capture_timer_pkg::PRE_ONE; // [R01]
    end
  end

  // Limit reached in the current direction
  logic atLimit;
  logic timeout;
  assign atLimit = countUp ? (count_q == capture_timer_pkg::CNT_TOP)
                           : (count_q == capture_timer_pkg::CNT_BOTTOM);
  assign timeout = step && atLimit; // [R14]

  // Counter; a reload write loads at once and beats a step
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      count_q <= capture_timer_pkg::COUNT_RST;
    end else if (wrReload) begin
      count_q <= wrData16; // [R05]
    end else if (step) begin
      if (atLimit && periodic) begin
        count_q <= reload_q; // [R14]
      end else if (countUp) begin
        count_q <= count_q + capture_timer_pkg::CNT_ONE; // [R01] [R10]
      end else begin
        count_q <= count_q - capture_timer_pkg::CNT_ONE; // [R01] [R10]
      end
    end
  end

  // Reload register
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      reload_q <= capture_timer_pkg::RELOAD_RST;
    end else if (wrReload) begin
      reload_q <= wrData16; // [R05]
    end
  end

  // Control register; reserved bits never store
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ctrl_q <= capture_timer_pkg::CTRL_RST; // [R11] [R12]
    end else if (wrCtrl) begin
      ctrl_q <= busReq.wdata & capture_timer_pkg::CTRL_MASK; // [R15]
    end
  end

  // Pending interrupt; a timeout in the clear cycle wins
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      irq_q <= 1'b0;
    end else if (timeout) begin
      irq_q <= 1'b1; // [R14]
    end else if (wrClear) begin
      irq_q <= 1'b0; // [R04]
    end
  end
  assign timerIrq = irq_q; // [R15]

  // Selected capture source; codes above 17 select nothing
  logic evtSel;
  logic evtRise;
  assign evtSel = (capSel < 5'(capture_timer_pkg::NUM_EVT)) ?
    eventSources[capSel] : 1'b0; // [R08]
  assign evtRise = evtSel && !evtPrev_q;

  // Edge memory, so only the first assertion captures
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      evtPrev_q <= 1'b0;
    end else begin
      evtPrev_q <= evtSel;
    end
  end

  // Capture register; the counter is never disturbed by it
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      capt_q <= capture_timer_pkg::CAPT_RST;
    end else if (capGate && evtRise) begin
      capt_q <= count_q; // [R02] [R07]
    end
  end

  // Read mux; write-only and unmapped addresses read zero
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rdData_q <= '0;
    end else if (busReq.rd) begin
      case (busReq.addr)
        capture_timer_pkg::RELOAD_ADDR: rdData_q <= {16'h0000, reload_q};
        capture_timer_pkg::COUNT_ADDR:
          rdData_q <= {16'h0000, count_q}; // [R06] [R03]
        capture_timer_pkg::CTRL_ADDR: rdData_q <= ctrl_q; // [R15]
        capture_timer_pkg::CAPT_ADDR:
          rdData_q <= {16'h0000, capt_q}; // [R03]
        default: rdData_q <= '0; // [R04]
      endcase
    end else begin
      rdData_q <= '0;
    end
  end
  assign rdData = rdData_q;

  // Checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  logic capWr;
  assign capWr = busReq.wr && (busReq.addr == capture_timer_pkg::CAPT_ADDR);

  chk_cap_latch: assert property ( // [R02]
    capGate && evtRise |=> capt_q == $past(count_q))
    else $error("capture did not take the count");
  chk_cap_gated: assert property ( // [R07]
    !capGate |=> $stable(capt_q))
    else $error("capture moved while gated off");
  chk_capt_ro: assert property ( // [R03]
    capWr && !(capGate && evtRise) |=> $stable(capt_q))
    else $error("capture register took a write");
  chk_irq_clear: assert property ( // [R04]
    irq_q && wrClear && !timeout |=> !irq_q)
    else $error("clear write left interrupt pending");
  chk_irq_hold: assert property ( // [R15]
    irq_q && !wrClear |=> irq_q)
    else $error("interrupt dropped without clear");
  chk_reload_load: assert property ( // [R05]
    wrReload |=> count_q == $past(wrData16) && reload_q == count_q)
    else $error("reload write not loaded");
  chk_count_read: assert property ( // [R06]
    busReq.rd && busReq.addr == capture_timer_pkg::COUNT_ADDR
    |=> rdData == {16'h0000, $past(count_q)})
    else $error("count read wrong");
  chk_halt_stop: assert property ( // [R11]
    !timerRun && !wrReload |=> $stable(count_q))
    else $error("counter moved while stopped");
  chk_dir_step: assert property ( // [R10]
    step && !atLimit && !wrReload |=> count_q ==
    ($past(countUp) ? $past(count_q) + 16'h0001
                    : $past(count_q) - 16'h0001))
    else $error("step went the wrong way");
  chk_periodic_reload: assert property ( // [R14]
    timeout && periodic && !wrReload |=> count_q == $past(reload_q) && irq_q)
    else $error("periodic timeout wrong");
  chk_free_wrap: assert property ( // [R14]
    timeout && !periodic && !wrReload
    |=> count_q == ~$past(count_q) && irq_q)
    else $error("free-running wrap wrong");
  chk_ctrl_rsvd: assert property ( // [R15]
    busReq.rd && busReq.addr == capture_timer_pkg::CTRL_ADDR
    |=> (rdData & ~capture_timer_pkg::CTRL_MASK) == 32'h00000000)
    else $error("reserved control bits read nonzero");
  chk_div16_tick: assert property ( // [R13]
    preTick && scaleSel == capture_timer_pkg::SCALE_DIV16
    |-> preCnt_q == capture_timer_pkg::PRE_TC_16)
    else $error("divide by 16 tick early");

  // Bus answers: data only in the cycle after a read, zero otherwise
  chk_idle_read: assert property ( // [R06]
    !busReq.rd |=> rdData == 32'h00000000)
    else $error("read data shown without a read");
  chk_clear_read: assert property ( // [R04]
    busReq.rd && busReq.addr == capture_timer_pkg::CLEAR_ADDR
    |=> rdData == 32'h00000000)
    else $error("clear register read nonzero");

  // Capture select codes past the last source never latch
  chk_high_sel: assert property ( // [R08]
    capSel >= 5'(capture_timer_pkg::NUM_EVT) |=> $stable(capt_q))
    else $error("capture from a select code out of range");

  // A step needs a tick of the chosen source; code 11 never steps
  chk_src_step: assert property ( // [R09]
    step |-> (clkSel == capture_timer_pkg::CLK_OSC32K && osc32kTick) ||
    (clkSel == capture_timer_pkg::CLK_CORE_DIV && coreDivTick) ||
    (clkSel == capture_timer_pkg::CLK_FAST && fastTick))
    else $error("step without a tick of the chosen source");

  // Main scenarios that the random runs should reach

  cov_capture: cover property (capGate && evtRise && timerRun);
  cov_periodic: cover property (timeout && periodic);
  cov_wrap_up: cover property (timeout && !periodic && countUp);
  cov_clear: cover property (irq_q ##1 wrClear ##1 !irq_q);
  cov_wrap_down: cover property (timeout && !periodic && !countUp);

endmodule
`default_nettype wire

// file: pkg/capture_timer_pkg.sv
/*
  Constants, types and register map of the 16-bit capture timer.
  Assumes byte addresses on a 32-bit register port.
*/
`default_nettype none
package capture_timer_pkg;
  // Widths and counts
  localparam int DATA_W = 32;
  localparam int CNT_W = 16;
  localparam int PRE_W = 15;
  localparam int NUM_EVT = 18;
  localparam int SEL_W = 5;
  // Register byte addresses
  localparam logic [31:0] RELOAD_ADDR = 32'hffff0380;
  localparam logic [31:0] COUNT_ADDR = 32'hffff0384;
  localparam logic [31:0] CTRL_ADDR = 32'hffff0388;
  localparam logic [31:0] CLEAR_ADDR = 32'hffff038c;
  localparam logic [31:0] CAPT_ADDR = 32'hffff0390;
  // Control field positions
  localparam int CAP_GATE_BIT = 17;
  localparam int CAP_SEL_LSB = 12;
  localparam int CLK_SEL_LSB = 9;
  localparam int DIR_BIT = 8;
  localparam int RUN_BIT = 7;
  localparam int PER_BIT = 6;
  localparam int SCALE_LSB = 0;
  // Writable control bits; the rest read as zero
  localparam logic [31:0] CTRL_MASK = 32'h0003f7cf;
  // Reset values
  localparam logic [15:0] RELOAD_RST = 16'h0000;
  localparam logic [15:0] COUNT_RST = 16'hffff;
  localparam logic [31:0] CTRL_RST = 32'h00000000;
  localparam logic [15:0] CAPT_RST = 16'h0000;
  // Count limits
  localparam logic [15:0] CNT_TOP = 16'hffff;
  localparam logic [15:0] CNT_BOTTOM = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  // Prescale codes and their terminal counts
  localparam logic [3:0] SCALE_DIV16 = 4'h4;
  localparam logic [3:0] SCALE_DIV256 = 4'h8;
  localparam logic [3:0] SCALE_DIV32K = 4'hf;
  localparam logic [14:0] PRE_TC_1 = 15'h0000;
  localparam logic [14:0] PRE_TC_16 = 15'h000f;
  localparam logic [14:0] PRE_TC_256 = 15'h00ff;
  localparam logic [14:0] PRE_TC_32K = 15'h7fff;
  localparam logic [14:0] PRE_ONE = 15'h0001;
  // Timer clock sources
  typedef enum logic [1:0] {
    CLK_OSC32K = 2'b00,
    CLK_CORE_DIV = 2'b01,
    CLK_FAST = 2'b10,
    CLK_RSVD = 2'b11
  } clk_src_e;
  // One register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [31:0] addr;
    logic [31:0] wdata;
  } bus_req_s;
endpackage
`default_nettype wire

// file: tb/capture_timer_test.sv
/*
  Self-checking bench for the 16-bit capture timer with a cycle model.
  Assumes ticks are sys_clk pulses and events sys_clk-synchronous levels, both driven by this bench.
*/
`timescale 1ns/10ps
`default_nettype none
module capture_timer_test;
  // Clock, reset and design ports
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  capture_timer_pkg::bus_req_s busReq = '0;
  logic [31:0] rdData;
  logic osc32kTick = 1'b0;
  logic coreDivTick = 1'b0;
  logic fastTick = 1'b0;
  logic [17:0] eventSources = '0;
  logic timerIrq;
  // Scoreboard counts
  int failures = 0;
  int checks_done = 0;
  // Model state, held as integers
  int mReload, mCount, mCap, mIrq, mPre, mRd, mDiv, seedUse;
  logic [31:0] mCtrl;
  bit mPrev, live, evOn, step, lim, evt, tk;
  // Every mapped place plus the clear and one unmapped address
  logic [31:0] addrs [6] = '{capture_timer_pkg::RELOAD_ADDR,
    capture_timer_pkg::COUNT_ADDR, capture_timer_pkg::CTRL_ADDR,
    capture_timer_pkg::CLEAR_ADDR, capture_timer_pkg::CAPT_ADDR,
    32'hffff0394};

  capture_timer u_capture_timer (
    .sys_clk(sys_clk), .rstn(rstn), .busReq(busReq), .rdData(rdData),
    .osc32kTick(osc32kTick), .coreDivTick(coreDivTick),
    .fastTick(fastTick), .eventSources(eventSources), .timerIrq(timerIrq)
  );

  // Free-running 125 MHz clock
  always #4 sys_clk = ~sys_clk;

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Model: compare last edge's outputs, then advance with sampled inputs
  always @(posedge sys_clk) begin
    if (live) begin
      check("rdData", rdData, 32'(mRd));
      check("timerIrq", {31'h0, timerIrq}, 32'(mIrq));
    end
    mRd = 0;
    if (!rstn) begin
      // Reset values from the register table
      mReload = 0;
      mCount = 'hffff;
      mCtrl = '0;
      mCap = 0;
      mIrq = 0;
      mPre = 0;
      mPrev = 1'b0;
      live = 1'b1;
    end else begin
      // Reads return state from before this edge; clear reads as zero
      if (busReq.rd) begin
        case (busReq.addr)
          capture_timer_pkg::RELOAD_ADDR: mRd = mReload;
          capture_timer_pkg::COUNT_ADDR: mRd = mCount;
          capture_timer_pkg::CTRL_ADDR: mRd = int'(mCtrl);
          capture_timer_pkg::CAPT_ADDR: mRd = mCap;
          default: mRd = 0;
        endcase
      end
      // Source select, code 11 never steps
      case (mCtrl[10:9])
        2'b00: tk = osc32kTick;
        2'b01: tk = coreDivTick;
        2'b10: tk = fastTick;
        default: tk = 1'b0;
      endcase
      case (mCtrl[3:0])
        4'h4: mDiv = 16;
        4'h8: mDiv = 256;
        4'hf: mDiv = 32768;
        default: mDiv = 1;
      endcase
      step = mCtrl[7] && tk && mPre == mDiv - 1;
      if (!mCtrl[7]) mPre = 0;
      else if (tk) mPre = step ? 0 : mPre + 1;
      // Capture takes the count of the cycle the selected event rises
      evt = mCtrl[16:12] < 5'd18 ? eventSources[mCtrl[16:12]] : 1'b0;
      if (mCtrl[17] && evt && !mPrev) mCap = mCount;
      mPrev = evt;
      lim = step && mCount == (mCtrl[8] ? 'hffff : 0);
      // Timeout sets the interrupt and beats a clear in the same cycle
      if (busReq.wr && busReq.addr == capture_timer_pkg::CLEAR_ADDR) mIrq = 0;
      if (lim) mIrq = 1;
      if (busReq.wr && busReq.addr == capture_timer_pkg::RELOAD_ADDR) begin
        mReload = int'(busReq.wdata[15:0]);
        mCount = mReload;
      end else if (lim) begin
        mCount = mCtrl[6] ? mReload : (mCtrl[8] ? 0 : 'hffff);
      end else if (step) begin
        mCount = mCtrl[8] ? mCount + 1 : mCount - 1;
      end
      if (busReq.wr && busReq.addr == capture_timer_pkg::CTRL_ADDR) begin
        mCtrl = busReq.wdata & capture_timer_pkg::CTRL_MASK;
      end
    end
  end

  // One bus cycle with random ticks of the given percent density
  task automatic cyc(bit w, bit r, logic [31:0] a, logic [31:0] d, int dens);
    @(posedge sys_clk);
    busReq.wr <= w;
    busReq.rd <= r;
    busReq.addr <= a;
    busReq.wdata <= d;
    osc32kTick <= int'($urandom % 100) < dens;
    coreDivTick <= int'($urandom % 100) < dens;
    fastTick <= int'($urandom % 100) < dens;
    // Sparse event toggles; held low while the selection changes
    if (evOn) eventSources <= eventSources ^ (18'($urandom) & 18'($urandom)
      & 18'($urandom) & 18'($urandom));
    else eventSources <= '0;
  endtask

  // Stop first so the prescaler starts from zero, then apply the setup
  task automatic setup(logic [31:0] c);
    evOn = 1'b0;
    cyc(1'b1, 1'b0, capture_timer_pkg::CTRL_ADDR, 32'h0, 0);
    cyc(1'b1, 1'b0, capture_timer_pkg::CTRL_ADDR, c, 0);
    evOn = 1'b1;
  endtask

  initial begin
    int op;
    logic [31:0] c;
    seedUse = $urandom(56239);
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    // Reset values, clear and unmapped reads
    foreach (addrs[i]) cyc(1'b0, 1'b1, addrs[i], 32'h0, 0);
    // Writes to read-only and unmapped places; reserved bits stay zero
    foreach (addrs[i]) cyc(1'b1, 1'b0, addrs[i], 32'hffffffff, 0);
    foreach (addrs[i]) cyc(1'b0, 1'b1, addrs[i], 32'h0, 0);
    $display("test register_access done");
    // Random setups: every source, direction, mode and divisor but /32768
    for (int n = 0; n < 60; n++) begin
      c = $urandom & 32'h0003f7c0;
      c[3:0] = (n % 4 == 3) ? 4'h8 : ((n % 4 == 2) ? 4'h4 : 4'h0);
      c[7] = (n % 9 != 0);
      setup(c);
      cyc(1'b1, 1'b0, capture_timer_pkg::RELOAD_ADDR,
        (n % 2) ? $urandom : {16'h0, 14'h0, 2'($urandom)} ^ {16'h0,
        {16{n[2]}}}, 0);
      repeat (300) begin
        op = int'($urandom % 8);
        // Reload only without prescaling, so its effect is unambiguous
        if (op == 2 && c[3:0] == 4'h0)
          cyc(1'b1, 1'b0, capture_timer_pkg::RELOAD_ADDR, $urandom, 0);
        else if (op == 1)
          cyc(1'b1, 1'b0, capture_timer_pkg::CLEAR_ADDR, $urandom, 60);
        else if (op == 3)
          cyc(1'b1, 1'b0, addrs[1 + 3 * ($urandom % 2)], $urandom, 60);
        else if (op < 3)
          cyc(1'b0, 1'b1, addrs[$urandom % 6], 32'h0, 60);
        else cyc(1'b0, 1'b0, 32'h0, 32'h0, 60);
      end
    end
    $display("test random_setups done");
    // Divide by 32768 on the fast source, counting up past the top
    setup(32'h0);
    cyc(1'b1, 1'b0, capture_timer_pkg::RELOAD_ADDR, 32'h0000fffe, 0);
    setup(32'h0000058f);
    repeat (66000) begin
      if ($urandom % 500 == 0) cyc(1'b0, 1'b1, addrs[1], 32'h0, 100);
      else cyc(1'b0, 1'b0, 32'h0, 32'h0, 100);
    end
    cyc(1'b0, 1'b1, addrs[1], 32'h0, 0);
    // Let the last read's answer reach the model's compare
    repeat (3) cyc(1'b0, 1'b0, 32'h0, 32'h0, 0);
    $display("test long_prescale done");
    report_and_stop();
  end
endmodule
`default_nettype wire
